// ---- hw/fofr_pkg.sv ----
package fofr_pkg;
  // command codes of the two configuration bytes
  localparam logic [7:0] CMD_RESP_CFG = 8'hCA;
  localparam logic [7:0] CMD_UNIT_CFG = 8'hC8;
  // reset values
  localparam logic [7:0] RESP_CFG_RST = 8'h00;
  localparam logic [7:0] UNIT_CFG_RST = 8'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;
  // field positions in the response byte
  localparam int RESP_MSB = 7;
  localparam int RESP_LSB = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int DLY_MSB = 2;
  localparam int DLY_LSB = 0;
  // current fault unit field in the delay unit byte
  localparam int IUNIT_MSB = 3;
  localparam int IUNIT_LSB = 2;
  // response and retry encodings
  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_SHUT = 2'h3;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;
  // unit lengths in milliseconds per code
  localparam logic [8:0] UNIT_MS_0 = 9'h001;
  localparam logic [8:0] UNIT_MS_1 = 9'h004;
  localparam logic [8:0] UNIT_MS_2 = 9'h010;
  localparam logic [8:0] UNIT_MS_3 = 9'h100;
  // base tick: one millisecond of the system clock
  localparam int CLK_HZ = 20000000;
  localparam int BASE_TICK_MS = 1;
  localparam int MS_CYCLES = (CLK_HZ / 1000) * BASE_TICK_MS;
  localparam int MS_CNT_W = 16;

  // milliseconds per delay unit for a two bit code
  function automatic logic [8:0] unit_ms(input logic [1:0] code);
    logic [8:0] r;
    r = UNIT_MS_0;
    case (code)
      2'h0: r = UNIT_MS_0;
      2'h1: r = UNIT_MS_1;
      2'h2: r = UNIT_MS_2;
      default: r = UNIT_MS_3;
    endcase
    return r;
  endfunction : unit_ms
endpackage : fofr_pkg

// ---- hw/fofr_top.sv ----
`timescale 1ns/1ps
module fofr_top #(
  parameter int MS_CYCLES = fofr_pkg::MS_CYCLES // cycles per millisecond tick
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic fast_oc_pin, // comparator output, asynchronous
  input wire logic output_enable, // output requested on, same clock
  input wire logic fault_clear, // one-cycle clear of the latched fault
  input wire logic cmd_wr, // write strobe for cmd_code
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_wdata,
  output logic [7:0] cmd_rdata, // readback of cmd_code, registered
  output logic output_on,
  output logic limit_slow, // hold current at the slow threshold
  output logic limit_fast, // hold current at the fast threshold
  output logic fault_flag, // sticky status bit
  output logic host_notify, // one-cycle notification pulse
  output logic off_latched // output held off until cleared
);
  typedef enum logic [1:0] {ST_RUN, ST_LIMIT, ST_WAIT, ST_LATCHED} fofr_state_t;

  // synchroniser: s1 only feeds s2
  logic s1_q, s2_q, s3_q, flt_q, flt_d;
  always_comb begin
    // filtered level moves only when the last two stages agree
    flt_d = (s2_q == s3_q) ? s3_q : flt_q;
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      flt_q <= 1'b0;
    end else begin
      s1_q <= fast_oc_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      flt_q <= flt_d;
    end
  end

  // configuration bytes and readback
  logic [7:0] resp_cfg_q, resp_cfg_d; // fast_overcurrent_response_config
  logic [7:0] unit_cfg_q, unit_cfg_d; // fault_delay_unit_config
  logic [7:0] rdata_d;
  always_comb begin
    resp_cfg_d = resp_cfg_q;
    unit_cfg_d = unit_cfg_q;
    if (cmd_wr && cmd_code == fofr_pkg::CMD_RESP_CFG) begin
      resp_cfg_d = cmd_wdata;
    end
    if (cmd_wr && cmd_code == fofr_pkg::CMD_UNIT_CFG) begin
      unit_cfg_d = cmd_wdata;
    end
    // unknown codes read as zero
    if (cmd_code == fofr_pkg::CMD_RESP_CFG) begin
      rdata_d = resp_cfg_q;
    end else if (cmd_code == fofr_pkg::CMD_UNIT_CFG) begin
      rdata_d = unit_cfg_q;
    end else begin
      rdata_d = fofr_pkg::RDATA_RST;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      resp_cfg_q <= fofr_pkg::RESP_CFG_RST;
      unit_cfg_q <= fofr_pkg::UNIT_CFG_RST;
      cmd_rdata <= fofr_pkg::RDATA_RST;
    end else begin
      resp_cfg_q <= resp_cfg_d;
      unit_cfg_q <= unit_cfg_d;
      cmd_rdata <= rdata_d;
    end
  end

  // field views
  logic [1:0] resp;
  logic [2:0] retry, dly;
  logic [8:0] unit_len;
  assign resp = resp_cfg_q[fofr_pkg::RESP_MSB:fofr_pkg::RESP_LSB];
  assign retry = resp_cfg_q[fofr_pkg::RETRY_MSB:fofr_pkg::RETRY_LSB];
  assign dly = resp_cfg_q[fofr_pkg::DLY_MSB:fofr_pkg::DLY_LSB];
  assign unit_len = fofr_pkg::unit_ms(unit_cfg_q[fofr_pkg::IUNIT_MSB:fofr_pkg::IUNIT_LSB]);

  // response state machine with its delay timer
  fofr_state_t st_q, st_d;
  logic [fofr_pkg::MS_CNT_W-1:0] ms_q, ms_d; // cycles within a millisecond
  logic [8:0] ucnt_q, ucnt_d; // milliseconds within a unit
  logic [2:0] units_q, units_d; // whole units elapsed
  logic [2:0] tries_q, tries_d; // restart attempts made
  logic en_q, flag_d, notify_d, on_d, slow_d, fast_d;
  logic ms_tick, unit_tick, expire, clr_tmr;
  always_comb begin
    st_d = st_q;
    tries_d = tries_q;
    clr_tmr = 1'b0;
    ms_tick = (ms_q == fofr_pkg::MS_CNT_W'(MS_CYCLES - 1));
    unit_tick = ms_tick && (ucnt_q == unit_len - 9'h001);
    // delay is count of whole units
    expire = (units_q == dly);
    case (st_q)
      ST_RUN: begin
        // fast fault starts the limiting delay
        if (flt_q && resp == fofr_pkg::RESP_SHUT) begin
          st_d = ST_LIMIT;
          clr_tmr = 1'b1;
        end
      end
      ST_LIMIT: begin
        if (!flt_q || resp != fofr_pkg::RESP_SHUT) begin
          st_d = ST_RUN;
        end else if (expire) begin
          clr_tmr = 1'b1;
          if (retry == fofr_pkg::RETRY_NONE) begin
            st_d = ST_LATCHED;
          end else if (retry != fofr_pkg::RETRY_FOREVER && tries_q == retry) begin
            st_d = ST_LATCHED;
          end else begin
            st_d = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (expire) begin
          st_d = ST_RUN;
          if (retry != fofr_pkg::RETRY_FOREVER) begin
            tries_d = tries_q + 3'h1;
          end
        end
      end
      ST_LATCHED: begin
        st_d = ST_LATCHED;
      end
      default: begin
        st_d = ST_RUN;
      end
    endcase
    // fresh episode on clear or re-enable
    if (fault_clear || (output_enable && !en_q)) begin
      st_d = ST_RUN;
      tries_d = 3'h0;
      clr_tmr = 1'b1;
    end
    // timer chain: ms, then ms per unit, then units
    if (clr_tmr) begin
      ms_d = '0;
      ucnt_d = 9'h000;
      units_d = 3'h0;
    end else begin
      ms_d = ms_tick ? '0 : ms_q + 1'b1;
      ucnt_d = unit_tick ? 9'h000 : (ms_tick ? ucnt_q + 9'h001 : ucnt_q);
      units_d = (unit_tick && !expire) ? units_q + 3'h1 : units_q;
    end
    flag_d = flt_q ? 1'b1 : (fault_clear ? 1'b0 : fault_flag);
    notify_d = flt_d && !flt_q;
    // ignore mode only limits, never shuts
    slow_d = flt_q && resp != fofr_pkg::RESP_SHUT;
    fast_d = (st_d == ST_LIMIT);
    on_d = output_enable && (st_d == ST_RUN || st_d == ST_LIMIT);
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q <= ST_RUN;
      ms_q <= '0;
      ucnt_q <= 9'h000;
      units_q <= 3'h0;
      tries_q <= 3'h0;
      en_q <= 1'b0;
      fault_flag <= 1'b0;
      host_notify <= 1'b0;
      limit_slow <= 1'b0;
      limit_fast <= 1'b0;
      output_on <= 1'b0;
      off_latched <= 1'b0;
    end else begin
      st_q <= st_d;
      ms_q <= ms_d;
      ucnt_q <= ucnt_d;
      units_q <= units_d;
      tries_q <= tries_d;
      en_q <= output_enable;
      fault_flag <= flag_d;
      host_notify <= notify_d;
      limit_slow <= slow_d;
      limit_fast <= fast_d;
      output_on <= on_d;
      off_latched <= (st_d == ST_LATCHED);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // flag is registered from the filtered level, so it follows one cycle later
  AST_FLAG_SET: assert property ($rose(flt_q) |=> fault_flag)
    else $error("fault flag not set on fault");
  // notify is launched on the same edge that raises the filtered level
  AST_NOTIFY: assert property ($rose(flt_q) |-> host_notify)
    else $error("host not notified");
  AST_IGNORE_ON: assert property (resp == fofr_pkg::RESP_IGNORE && st_q == ST_RUN &&
      $stable(resp_cfg_q) && flt_q && output_enable |=> output_on && st_q == ST_RUN)
    else $error("ignore mode left run");
  AST_SLOW_LIM: assert property (resp == fofr_pkg::RESP_IGNORE && flt_q |=> limit_slow)
    else $error("slow limit missing");
  AST_FAST_LIM: assert property (st_q == ST_LIMIT |-> limit_fast)
    else $error("fast limit missing while limiting");
  AST_NO_RETRY: assert property (st_q == ST_LIMIT && st_d == ST_WAIT
      |-> retry != fofr_pkg::RETRY_NONE)
    else $error("restart with retry zero");
  AST_TRIES_MAX: assert property (retry != fofr_pkg::RETRY_FOREVER && $stable(retry)
      && $past(tries_q) <= retry |-> tries_q <= retry)
    else $error("too many restarts");
  AST_FOREVER: assert property (st_q == ST_LIMIT && expire && flt_q && !fault_clear &&
      en_q == output_enable && resp == fofr_pkg::RESP_SHUT &&
      retry == fofr_pkg::RETRY_FOREVER |=> st_q == ST_WAIT)
    else $error("endless retry latched");
  AST_LATCH_OFF: assert property (st_q == ST_LATCHED |-> !output_on)
    else $error("output on while latched");
  AST_WAIT_LEN: assert property (st_q == ST_WAIT && units_q < dly |=> st_q == ST_WAIT
      || $past(fault_clear) || ($past(output_enable) && !$past(en_q)))
    else $error("restart spacing too short");
  AST_CLR_TRIES: assert property (fault_clear |=> tries_q == 3'h0)
    else $error("attempt count not cleared");

  COV_LIMIT: cover property (st_q == ST_RUN ##1 st_q == ST_LIMIT);
  COV_RESTART: cover property (st_q == ST_WAIT ##1 st_q == ST_RUN);
  COV_LATCH: cover property (st_q == ST_LIMIT ##1 st_q == ST_LATCHED);
  COV_CLEAR: cover property (st_q == ST_LATCHED && fault_clear);
endmodule : fofr_top

// ---- test/fofr_host.sv ----
`timescale 1ns/1ps
// host side of the command port: one byte per strobe, changes after an edge
module fofr_host (
  input wire logic clk_sys,
  output logic cmd_wr,
  output logic [7:0] cmd_code,
  output logic [7:0] cmd_wdata
);
  // idle values from time zero
  initial begin
    cmd_wr = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 8'h00;
  end
  // single byte write; strobe stands for one edge only
  task automatic wr(input logic [7:0] code, input logic [7:0] data);
    @(posedge clk_sys);
    cmd_wr <= 1'b1;
    cmd_code <= code;
    cmd_wdata <= data;
    @(posedge clk_sys);
    cmd_wr <= 1'b0;
  endtask : wr
  // select a code; readback is registered, so look after the next edge
  task automatic sel(input logic [7:0] code);
    @(posedge clk_sys);
    cmd_code <= code;
    @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : sel
endmodule : fofr_host

// ---- test/fofr_top_tb.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module fofr_top_tb;
  localparam int M = 8; // short millisecond so delays stay small
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic pin = 1'b0;
  logic oen = 1'b0;
  logic fclr = 1'b0;
  logic cmd_wr;
  logic [7:0] cmd_code;
  logic [7:0] cmd_wdata;
  logic [7:0] rdata;
  logic on, lslow, lfast, flag, notify, latched;
  int fails = 0;
  int samples_checked = 0;
  int notes = 0; // notification pulses seen
  int cnt;
  int fcnt; // cycles seen at the fast limit
  logic prev_on; // output level at the previous look
  always #25 clk_sys = ~clk_sys;
  fofr_host host (.clk_sys(clk_sys), .cmd_wr(cmd_wr), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata));
  fofr_top #(.MS_CYCLES(M)) DUT (.clk_sys(clk_sys), .rst(rst), .fast_oc_pin(pin),
    .output_enable(oen), .fault_clear(fclr), .cmd_wr(cmd_wr), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .cmd_rdata(rdata), .output_on(on), .limit_slow(lslow),
    .limit_fast(lfast), .fault_flag(flag), .host_notify(notify), .off_latched(latched));
  // count notification pulses, one per fault episode
  always @(posedge clk_sys) if (notify === 1'b1) notes++;
  // verdict
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  // wait six cycles, then clear the fault with the pin low
  task automatic clear_fault;
    @(posedge clk_sys);
    pin <= 1'b0;
    repeat (6) @(posedge clk_sys);
    fclr <= 1'b1;
    @(posedge clk_sys);
    fclr <= 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask : clear_fault
  // persistent fault; cycles until the output is latched off
  task automatic trial(input logic [2:0] n, input logic [1:0] u, input int ums);
    int lo;
    lo = (2 * n + 1) * ums * M;
    cnt = 0;
    fcnt = 0;
    host.wr(8'hC8, {4'h0, u, 2'h0});
    host.wr(8'hCA, {2'h3, n, 3'h1});
    @(posedge clk_sys);
    pin <= 1'b1;
    while (latched !== 1'b1 && cnt < 3000) begin
      @(negedge clk_sys);
      cnt++;
      if (lfast === 1'b1) fcnt++;
    end
    `CHK("fast_min", 1'b1, fcnt >= (n + 1) * ums * M)
    `CHK("fast_max", 1'b1, fcnt <= (n + 1) * (ums * M + 2))
    `CHK("latch_late", 1'b1, cnt >= lo)
    `CHK("latch_soon", 1'b1, cnt <= lo + 8 + 2 * (2 * n + 1))
    `CHK("off_on", 1'b0, on)
    clear_fault();
    `CHK("restart_on", 1'b1, on)
    `CHK("restart_latch", 1'b0, latched)
  endtask : trial
  // hang guard, far beyond the expected run
  initial begin
    #(50 * 40000);
    fails++;
    report_and_stop();
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    oen <= 1'b1;
    host.wr(8'hCA, 8'hD9);
    host.sel(8'hCA);
    `CHK("resp_cfg", 8'hD9, rdata)
    host.wr(8'h55, 8'hAA);
    host.sel(8'h55);
    `CHK("unmapped", 8'h00, rdata)
    host.wr(8'hC8, 8'h0C);
    host.sel(8'hC8);
    `CHK("unit_cfg", 8'h0C, rdata)
    $display("test registers done");
    // ignore mode: limit slowly and keep running
    host.wr(8'hCA, 8'h01);
    @(posedge clk_sys);
    pin <= 1'b1;
    repeat (300) @(negedge clk_sys);
    `CHK("slow_lim", 1'b1, lslow)
    `CHK("ign_on", 1'b1, on)
    `CHK("ign_fast", 1'b0, lfast)
    `CHK("ign_flag", 1'b1, flag)
    `CHK("ign_note", 1, notes)
    clear_fault();
    `CHK("flag_clr", 1'b0, flag)
    $display("test ignore done");
    // retry counts 0..3 then three slower units, counter must start fresh each time
    trial(3'h0, 2'h0, 1);
    trial(3'h1, 2'h0, 1);
    trial(3'h2, 2'h0, 1);
    trial(3'h3, 2'h0, 1);
    trial(3'h1, 2'h1, 4);
    trial(3'h0, 2'h2, 16);
    trial(3'h0, 2'h3, 256);
    `CHK("notes", 8, notes)
    $display("test retry done");
    // endless retry: never latched, output keeps coming back
    host.wr(8'hC8, 8'h00);
    host.wr(8'hCA, 8'hF9);
    @(posedge clk_sys);
    pin <= 1'b1;
    cnt = 0;
    prev_on = on;
    repeat (400) begin
      @(negedge clk_sys);
      // count restarts: the output coming back after a wait
      if (on === 1'b1 && prev_on === 1'b0) cnt++;
      prev_on = on;
      `CHK("forever", 1'b0, latched)
    end
    // each restart costs a limit span and a wait span of one unit, plus a few cycles
    `CHK("retries_on", 1'b1, cnt >= 400 / (2 * M + 8))
    $display("test forever done");
    report_and_stop();
  end
endmodule : fofr_top_tb
